// [hw/msc_pkg.sv]
// constants and types shared by the matrix switch command executor
package msc_pkg;
  localparam int N_ROWS = 8;
  localparam int N_COLS = 8;
  localparam int XP_W = N_ROWS * N_COLS;
  localparam int XP_IW = $clog2(XP_W);
  localparam logic [6:0] MAX_SETUP = 7'h64;
  localparam logic [7:0] CH_X = 8'h58;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_Z = 8'h5a;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_N = 8'h4e;
  localparam logic [7:0] CH_V = 8'h56;
  localparam logic [7:0] CH_W = 8'h57;
  localparam logic [7:0] CH_Y = 8'h59;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_ROW_A = 8'h41;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [3:0] ROW_DIGITS = 4'h8;
  localparam logic [1:0] TERM_RST = 2'h0;
  localparam logic [2:0] ADDR_ERR = 3'h0;
  localparam logic [2:0] ADDR_MB = 3'h1;
  localparam logic [2:0] ADDR_BM = 3'h2;
  localparam logic [2:0] ADDR_STEP = 3'h3;
  localparam logic [2:0] ADDR_CTRL = 3'h4;
  localparam int ERR_OPT_BIT = 1;
  localparam int CTRL_EOI_BIT = 0;
  localparam int CTRL_TRIG_BIT = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_NUM = 5'h02,
    ST_BITS = 5'h04,
    ST_ROW = 5'h08,
    ST_COL = 5'h10
  } msc_state_t;
endpackage

// [hw/msc_exec.sv]
// command parser, buffered executor and terminator sender of the relay matrix
// How it works
// - break-first digits: 1 marks row break-before-make, 0 removes it
// - fewer than eight row digits: rows untouched, option error flag set
// - a row is make-first, break-first or don't care, never both
// - break-first select forces it; deselect keeps make-first, else don't care
// - make-first digits use same field with mirrored next-state rules
// - commands wait in a buffer until the execute character arrives
// - execute character also fires a trigger when trigger-on-execute is set
// - one group runs in fixed internal order; controller splits with execute
// - terminator 0 CR LF, 1 LF CR, 2 CR, 3 LF
// - power-up, device clear and restore defaults set terminator to 0
// - with EOI enabled, EOI rides on the last terminator byte
// - every talk appends the terminator whatever the data format
// - setup copy m to n, 0..100, 0 means the live relays
// - copying to the relays loads the step pointer with the source index
// - copy 0 to 0 resends relays unchanged and zeroes the step pointer
// - any mix of relay commands on the live relays gives one switching operation per execute
// - relay image built as aim, clear, copy, open, close; later wins
// - aim 0 edits the live relays; clear 0 opens every relay
// - option error latches until error word is read, read clears it
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
module msc_exec (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  input wire logic talk_req_in,
  output logic [7:0] tx_byte_out,
  output logic tx_valid_out,
  output logic tx_eoi_out,
  input wire logic tx_ready_in,
  input wire logic dev_clear_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic [msc_pkg::XP_W-1:0] relays_out,
  output logic relay_switch_out,
  output logic exec_trigger_out,
  output logic invalid_option_error_out
);
  import msc_pkg::*;
  msc_state_t state;
  logic [7:0] cmd, num, num1, bits;
  logic [3:0] ndig;
  logic [2:0] row;
  logic comma_seen, bad_digit, exec_go;
  logic [N_ROWS-1:0] mb_rows, bm_rows;
  logic [1:0] term_sel, ctrl;
  logic [6:0] edit_ptr, step_ptr;
  logic [XP_W-1:0] mem [0:100];
  logic e_pend, p_pend, z_pend, y_pend, r_pend, v_pend, w_pend, xp_pend;
  logic [6:0] e_val, p_val, z_src, z_dst;
  logic [1:0] y_val;
  logic [N_ROWS-1:0] v_mask, w_mask;
  logic [XP_W-1:0] open_m, close_m;
  logic tx_idx;
  function automatic logic [7:0] dec_step(input logic [7:0] acc, input logic [7:0] ch);
    logic [11:0] t;
    t = {4'h0, acc} * 12'h00a + {8'h00, ch[3:0]};
    dec_step = (t > 12'h0ff) ? 8'hff : t[7:0];
  endfunction
  function automatic logic [7:0] term_byte(input logic [1:0] sel, input logic idx);
    logic lf_first;
    lf_first = (sel == 2'h1) || (sel == 2'h3);
    term_byte = (lf_first ^ idx) ? CH_LF : CH_CR;
  endfunction
  function automatic logic term_last(input logic [1:0] sel, input logic idx);
    term_last = sel[1] | idx; // single-byte codes end at once
  endfunction
  // byte classification and handshake
  logic acc, is_dig, is_row, cont, close_cur, err_ev, err_clr;
  assign rx_ready_out = !exec_go; // stall while the buffer drains
  assign acc = rx_valid_in && rx_ready_out;
  assign is_dig = (rx_byte_in >= CH_ZERO) && (rx_byte_in <= CH_NINE);
  assign is_row = (rx_byte_in >= CH_ROW_A) && (rx_byte_in < CH_ROW_A + 8'(N_ROWS));
  assign cont = ((state == ST_NUM || state == ST_COL || state == ST_BITS) && is_dig) ||
                (state == ST_NUM && cmd == CH_Z && !comma_seen && rx_byte_in == CH_COMMA) ||
                (state == ST_ROW && is_row);
  assign close_cur = acc && state != ST_IDLE && !cont;
  // validity of the command being closed
  logic ok_cur;
  logic [XP_IW-1:0] xp_idx;
  always_comb begin
    xp_idx = XP_IW'({29'h0, row} * N_COLS + int'(num) - 1);
    unique case (state)
      ST_BITS: ok_cur = (ndig == ROW_DIGITS) && !bad_digit;
      ST_COL: ok_cur = (num != 8'h00) && (num <= 8'(N_COLS));
      ST_ROW: ok_cur = 1'b0;
      ST_NUM: begin
        if (cmd == CH_Y) ok_cur = num <= 8'h03;
        else if (cmd == CH_R) ok_cur = num == 8'h00;
        else if (cmd == CH_Z) ok_cur = comma_seen && num1 <= {1'b0, MAX_SETUP} && num <= {1'b0, MAX_SETUP};
        else ok_cur = num <= {1'b0, MAX_SETUP};
      end
      default: ok_cur = 1'b1;
    endcase
  end
  assign err_ev = close_cur && !ok_cur;
  assign err_clr = reg_rd_in && reg_addr_in == ADDR_ERR;
  // parser: one letter opens a command, a non-continuing byte closes it
  always_ff @(posedge clk_in) begin
    if (rst_in || dev_clear_in) begin
      state <= ST_IDLE;
      cmd <= 8'h00;
      num <= 8'h00;
      num1 <= 8'h00;
      bits <= 8'h00;
      ndig <= 4'h0;
      row <= 3'h0;
      comma_seen <= 1'b0;
      bad_digit <= 1'b0;
    end else if (acc && cont) begin
      if (state == ST_ROW) begin
        row <= 3'(rx_byte_in - CH_ROW_A);
        state <= ST_COL;
      end else if (rx_byte_in == CH_COMMA) begin
        num1 <= num;
        num <= 8'h00;
        comma_seen <= 1'b1;
      end else if (state == ST_BITS) begin
        if (ndig < ROW_DIGITS) bits <= {rx_byte_in[0], bits[7:1]}; // first digit lands on row A
        if (ndig != 4'hf) ndig <= ndig + 4'h1;
        if (rx_byte_in[3:1] != 3'h0) bad_digit <= 1'b1;
      end else begin
        num <= dec_step(num, rx_byte_in);
      end
    end else if (acc) begin
      cmd <= rx_byte_in;
      num <= 8'h00;
      ndig <= 4'h0;
      comma_seen <= 1'b0;
      bad_digit <= 1'b0;
      if (rx_byte_in == CH_V || rx_byte_in == CH_W) state <= ST_BITS;
      else if (rx_byte_in == CH_C || rx_byte_in == CH_N) state <= ST_ROW;
      else if (rx_byte_in == CH_E || rx_byte_in == CH_P || rx_byte_in == CH_Z ||
               rx_byte_in == CH_Y || rx_byte_in == CH_R) state <= ST_NUM;
      else state <= ST_IDLE; // unknown bytes and spaces are skipped
    end
  end
  // execute request: X closes any open command in the same byte
  always_ff @(posedge clk_in) begin
    if (rst_in || dev_clear_in) exec_go <= 1'b0;
    else exec_go <= acc && !cont && rx_byte_in == CH_X;
  end
  // command buffer; execution consumes and empties it
  always_ff @(posedge clk_in) begin
    if (rst_in || dev_clear_in || exec_go) begin
      {e_pend, p_pend, z_pend, y_pend, r_pend, v_pend, w_pend, xp_pend} <= 8'h00;
      e_val <= 7'h00;
      p_val <= 7'h00;
      z_src <= 7'h00;
      z_dst <= 7'h00;
      y_val <= 2'h0;
      v_mask <= '0;
      w_mask <= '0;
      open_m <= '0;
      close_m <= '0;
    end else if (close_cur && ok_cur) begin
      if (cmd == CH_E) {e_pend, e_val} <= {1'b1, num[6:0]};
      if (cmd == CH_P) {p_pend, p_val} <= {1'b1, num[6:0]};
      if (cmd == CH_Z) {z_pend, z_src, z_dst} <= {1'b1, num1[6:0], num[6:0]};
      if (cmd == CH_Y) {y_pend, y_val} <= {1'b1, num[1:0]};
      if (cmd == CH_R) r_pend <= 1'b1;
      if (cmd == CH_V) {v_pend, v_mask} <= {1'b1, bits};
      if (cmd == CH_W) {w_pend, w_mask} <= {1'b1, bits};
      if (cmd == CH_N) begin
        open_m[xp_idx] <= 1'b1;
        xp_pend <= 1'b1;
      end
      if (cmd == CH_C) begin
        close_m[xp_idx] <= 1'b1;
        xp_pend <= 1'b1;
      end
    end
  end
  // merged image: aim, clear, copy, open, close, each stage overriding
  logic [6:0] tgt;
  logic [XP_W-1:0] src, next_r, next_w;
  logic touch;
  always_comb begin
    tgt = e_pend ? e_val : edit_ptr; // aim 0 means the live relays
    src = (z_src == 7'h00) ? relays_out : mem[z_src];
    next_r = relays_out;
    next_w = (tgt == 7'h00) ? relays_out : mem[tgt];
    if (p_pend && p_val == 7'h00) next_r = '0;
    if (p_pend && p_val == tgt) next_w = '0;
    if (z_pend && z_dst == 7'h00) next_r = src;
    if (z_pend && z_dst == tgt) next_w = src;
    next_w = (next_w & ~open_m) | close_m;
    if (tgt == 7'h00) next_r = next_w;
    touch = (xp_pend && tgt == 7'h00) || (p_pend && p_val == 7'h00) || (z_pend && z_dst == 7'h00);
  end
  // relays, setup memory and pointers change only on execute
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      relays_out <= '0;
      relay_switch_out <= 1'b0;
      edit_ptr <= 7'h00;
      step_ptr <= 7'h00;
    end else begin
      relay_switch_out <= exec_go && touch; // one operation per execute
      if (exec_go) begin
        relays_out <= next_r;
        edit_ptr <= tgt;
        if (z_pend && z_dst == 7'h00) step_ptr <= z_src; // 0,0 zeroes it
        if (p_pend && p_val != 7'h00) mem[p_val] <= '0;
        if (z_pend && z_dst != 7'h00) mem[z_dst] <= src;
        if (tgt != 7'h00 && (xp_pend || (p_pend && p_val == tgt) || (z_pend && z_dst == tgt))) mem[tgt] <= next_w;
      end
    end
  end
  // trigger-on-execute pulse
  always_ff @(posedge clk_in) begin
    if (rst_in) exec_trigger_out <= 1'b0;
    else exec_trigger_out <= exec_go && ctrl[CTRL_TRIG_BIT];
  end
  // row modes: make-first applied before break-first inside one group
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mb_rows <= '0;
      bm_rows <= '0;
    end else if (exec_go) begin
      if (v_pend && w_pend) begin
        mb_rows <= v_mask & ~w_mask;
        bm_rows <= w_mask;
      end else if (v_pend) begin
        mb_rows <= v_mask;
        bm_rows <= bm_rows & ~v_mask;
      end else if (w_pend) begin
        bm_rows <= w_mask;
        mb_rows <= mb_rows & ~w_mask;
      end
    end
  end
  // terminator choice; clear and restore defaults return to CR LF
  always_ff @(posedge clk_in) begin
    if (rst_in || dev_clear_in) term_sel <= TERM_RST;
    else if (exec_go && y_pend) term_sel <= y_val;
    else if (exec_go && r_pend) term_sel <= TERM_RST;
  end
  // option error latch, a new error beats a simultaneous read
  always_ff @(posedge clk_in) begin
    if (rst_in) invalid_option_error_out <= 1'b0;
    else if (err_ev) invalid_option_error_out <= 1'b1;
    else if (err_clr) invalid_option_error_out <= 1'b0;
  end
  // register port: control write, status reads one cycle later
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl <= CTRL_RST;
      reg_rdata_out <= 8'h00;
    end else begin
      if (reg_wr_in && reg_addr_in == ADDR_CTRL) ctrl <= reg_wdata_in[1:0];
      reg_rdata_out <= 8'h00;
      if (reg_rd_in) begin
        unique case (reg_addr_in)
          ADDR_ERR: reg_rdata_out[ERR_OPT_BIT] <= invalid_option_error_out;
          ADDR_MB: reg_rdata_out <= mb_rows;
          ADDR_BM: reg_rdata_out <= bm_rows;
          ADDR_STEP: reg_rdata_out <= {1'b0, step_ptr};
          ADDR_CTRL: reg_rdata_out <= {4'h0, term_sel, ctrl};
          default: reg_rdata_out <= 8'h00;
        endcase
      end
    end
  end
  // terminator sender, started on a talk request while not already sending
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_valid_out <= 1'b0;
      tx_byte_out <= 8'h00;
      tx_eoi_out <= 1'b0;
      tx_idx <= 1'b0;
    end else if (!tx_valid_out && talk_req_in) begin
      tx_valid_out <= 1'b1;
      tx_idx <= 1'b0;
      tx_byte_out <= term_byte(term_sel, 1'b0);
      tx_eoi_out <= ctrl[CTRL_EOI_BIT] && term_last(term_sel, 1'b0);
    end else if (tx_valid_out && tx_ready_in) begin
      if (term_last(term_sel, tx_idx)) begin
        tx_valid_out <= 1'b0;
        tx_eoi_out <= 1'b0;
      end else begin
        tx_idx <= 1'b1;
        tx_byte_out <= term_byte(term_sel, 1'b1);
        tx_eoi_out <= ctrl[CTRL_EOI_BIT];
      end
    end
  end
  // checks; the default sequence is followed one step at a time, each step bounded
  sequence s_talk_start;
    !tx_valid_out && talk_req_in && term_sel == TERM_RST;
  endsequence
  sequence s_crlf;
    tx_valid_out && tx_byte_out == CH_CR;
  endsequence
  sequence s_cr_taken;
    tx_valid_out && tx_ready_in && !tx_idx && term_sel == TERM_RST;
  endsequence
  a_term_first: assert property (@(posedge clk_in) disable iff (rst_in) s_talk_start |=> s_crlf)
    else $error("terminator does not open with CR");
  a_term_second: assert property (@(posedge clk_in) disable iff (rst_in)
    s_cr_taken |=> tx_valid_out && tx_byte_out == CH_LF)
    else $error("CR not followed by LF");
  a_term_clear: assert property (@(posedge clk_in) disable iff (rst_in) dev_clear_in |=> term_sel == TERM_RST)
    else $error("device clear did not reset terminator");
  a_eoi_last: assert property (@(posedge clk_in) disable iff (rst_in)
    tx_valid_out && tx_eoi_out |-> term_last(term_sel, tx_idx) && ctrl[CTRL_EOI_BIT])
    else $error("eoi not on the last terminator byte");
  a_row_short: assert property (@(posedge clk_in) disable iff (rst_in)
    close_cur && state == ST_BITS && ndig != ROW_DIGITS |=> invalid_option_error_out)
    else $error("short row field not flagged");
  a_row_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    !(exec_go && (v_pend || w_pend)) |=> $stable(mb_rows) && $stable(bm_rows))
    else $error("row modes changed without a valid row command");
  a_row_excl: assert property (@(posedge clk_in) disable iff (rst_in) (mb_rows & bm_rows) == '0)
    else $error("row in both ordered modes");
  a_bm_select: assert property (@(posedge clk_in) disable iff (rst_in)
    exec_go && w_pend |=> (bm_rows & $past(w_mask)) == $past(w_mask))
    else $error("selected row not break-first");
  a_relay_hold: assert property (@(posedge clk_in) disable iff (rst_in) !exec_go |=> $stable(relays_out))
    else $error("relays moved without execute");
  a_exec_trig: assert property (@(posedge clk_in) disable iff (rst_in)
    exec_go && ctrl[CTRL_TRIG_BIT] |=> exec_trigger_out)
    else $error("execute did not trigger");
  a_step_load: assert property (@(posedge clk_in) disable iff (rst_in)
    exec_go && z_pend && z_dst == 7'h00 |=> step_ptr == $past(z_src))
    else $error("step pointer not loaded on copy to relays");
  a_one_switch: assert property (@(posedge clk_in) disable iff (rst_in) relay_switch_out |=> !relay_switch_out)
    else $error("more than one switch operation per execute");
  a_err_clear: assert property (@(posedge clk_in) disable iff (rst_in) err_clr && !err_ev |=> !invalid_option_error_out)
    else $error("error read did not clear flag");
endmodule

// [verification/msc_ctrl_model.sv]
// bus controller model: sends command strings, takes terminator bytes
`timescale 1ns/1ps
module msc_ctrl_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic rx_ready_in,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_valid_in,
  input wire logic tx_eoi_in,
  output logic tx_ready_out
);
  logic slow = 1'b0;
  logic [8:0] got[$];
  initial begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b1;
  end
  // a slow listener drops ready on every other cycle
  always @(posedge clk_in) tx_ready_out <= !slow || !tx_ready_out;
  // keep each byte beside its end flag
  always @(posedge clk_in) begin
    if (!rst_in && tx_valid_in && tx_ready_out) got.push_back({tx_eoi_in, tx_byte_in});
  end
  // byte held until taken; an X after each command fixes the order
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      rx_byte_out <= s[i];
      rx_valid_out <= 1'b1;
      @(negedge clk_in);
      while (!rx_ready_in) @(negedge clk_in);
      @(posedge clk_in);
    end
    rx_valid_out <= 1'b0;
    // released line flips so no stale byte lingers
    rx_byte_out <= ~rx_byte_out;
  endtask
endmodule

// [verification/msc_exec_test.sv]
// self-checking bench for the matrix switch command executor
`timescale 1ns/1ps
module msc_exec_test;
  import msc_pkg::*;
  logic clk_in, rst_in, talk, dclr, wr, rd, rdy, valid, txv, eoi, rdy_tx, sw, trig, err;
  logic [7:0] rxb, wd, rdata, txb, d;
  logic [2:0] addr;
  logic [XP_W-1:0] relays;
  int mismatches = 0, n_compared = 0, n_sw = 0, n_trig = 0;
  typedef struct {string cmd; logic [2:0] a; logic [7:0] ea; logic [2:0] b; logic [7:0] eb;
    logic [63:0] rel; int sw;} msc_row_t;
  msc_row_t rows[16] = '{
    '{"W11110000X", 3'h2, 8'h0f, 3'h1, 8'h00, 64'h0, 0},
    '{"V11000000X", 3'h1, 8'h03, 3'h2, 8'h0c, 64'h0, 0},
    '{"W00000000X", 3'h2, 8'h00, 3'h1, 8'h03, 64'h0, 0},
    '{"W10000000X", 3'h2, 8'h01, 3'h1, 8'h02, 64'h0, 0},
    '{"W1000X", 3'h2, 8'h01, 3'h0, 8'h02, 64'h0, 0},
    '{"X", 3'h0, 8'h00, 3'h1, 8'h02, 64'h0, 0},
    '{"E0P0CA1X", 3'h3, 8'h00, 3'h0, 8'h00, 64'h1, 1},
    '{"E0CB3X", 3'h0, 8'h00, 3'h2, 8'h01, 64'h401, 1},
    '{"E0Z0,5X", 3'h3, 8'h00, 3'h0, 8'h00, 64'h401, 0},
    '{"P0X", 3'h3, 8'h00, 3'h0, 8'h00, 64'h0, 1},
    '{"Z5,0NA1X", 3'h3, 8'h05, 3'h0, 8'h00, 64'h400, 1},
    '{"Z5,0CA1X", 3'h3, 8'h05, 3'h0, 8'h00, 64'h401, 1},
    '{"Z0,0X", 3'h3, 8'h00, 3'h0, 8'h00, 64'h401, 1},
    '{"E0NB3XE0CA2X", 3'h3, 8'h00, 3'h1, 8'h02, 64'h3, 2},
    '{"P0CA1NA1X", 3'h3, 8'h00, 3'h0, 8'h00, 64'h1, 1},
    '{"Z101,0X", 3'h0, 8'h02, 3'h3, 8'h00, 64'h1, 0}
  };
  msc_exec dut_u (.clk_in(clk_in), .rst_in(rst_in), .rx_byte_in(rxb), .rx_valid_in(valid),
    .rx_ready_out(rdy), .talk_req_in(talk), .tx_byte_out(txb), .tx_valid_out(txv), .tx_eoi_out(eoi),
    .tx_ready_in(rdy_tx), .dev_clear_in(dclr), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .relays_out(relays), .relay_switch_out(sw),
    .exec_trigger_out(trig), .invalid_option_error_out(err));
  msc_ctrl_model ctl_u (.clk_in(clk_in), .rst_in(rst_in), .rx_ready_in(rdy), .rx_byte_out(rxb),
    .rx_valid_out(valid), .tx_byte_in(txb), .tx_valid_in(txv), .tx_eoi_in(eoi), .tx_ready_out(rdy_tx));
  // clock at 25 MHz
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // pulse counters; n_sw cleared before each table case, n_trig only before the trigger-on check
  always @(posedge clk_in) begin
    if (sw === 1'b1) n_sw++;
    if (trig === 1'b1) n_trig++;
  end
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rdreg(input logic [2:0] a, input logic [7:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    @(negedge clk_in);
    check("reg read", exp, rdata);
    @(posedge clk_in);
  endtask
  task automatic wrreg(input logic [2:0] a, input logic [7:0] v);
    wr <= 1'b1;
    addr <= a;
    wd <= v;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic run(input string s);
    ctl_u.send(s);
    repeat (3) @(posedge clk_in);
  endtask
  // one talk request; y picks the expected terminator, en the end flag
  task automatic talk_chk(input int y, input logic en);
    logic [7:0] f;
    f = y[0] ? CH_LF : CH_CR;
    ctl_u.got.delete();
    talk <= 1'b1;
    @(posedge clk_in);
    talk <= 1'b0;
    repeat (8) @(posedge clk_in);
    check("term count", (y < 2) ? 2 : 1, ctl_u.got.size());
    if (ctl_u.got.size() > 0) check("term first", {(y < 2) ? 1'b0 : en, f}, ctl_u.got[0]);
    if (y < 2 && ctl_u.got.size() > 1) check("term last", {en, y[0] ? CH_CR : CH_LF}, ctl_u.got[1]);
  endtask
  // watchdog far beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    print_verdict();
  end
  initial begin
    {talk, dclr, wr, rd, wd, addr} = '0;
    rst_in = 1'b1;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rdreg(ADDR_CTRL, 8'h01);
    wrreg(3'h7, 8'hff);
    rdreg(3'h7, 8'h00);
    foreach (rows[i]) begin
      n_sw = 0;
      run(rows[i].cmd);
      check("relays", rows[i].rel, relays);
      check("switch count", rows[i].sw, n_sw);
      rdreg(rows[i].a, rows[i].ea);
      rdreg(rows[i].b, rows[i].eb);
    end
    check("trigger off", 0, n_trig);
    // short row field: flag raised, rows kept, read clears the flag
    run("V1X");
    check("error flag", 1, err);
    rdreg(ADDR_BM, 8'h01);
    rdreg(ADDR_ERR, 8'h02);
    check("error cleared", 0, err);
    // held commands wait for the execute byte
    ctl_u.send("E0CH8");
    repeat (6) @(posedge clk_in);
    check("held relays", 64'h1, relays);
    run("X");
    check("run relays", 64'h8000000000000001, relays);
    wrreg(ADDR_CTRL, 8'h03);
    n_trig = 0;
    run("X");
    check("trigger on", 1, n_trig);
    ctl_u.slow <= 1'b1;
    for (int y = 0; y < 4; y++) begin
      run($sformatf("Y%0dX", y));
      talk_chk(y, 1'b1);
    end
    wrreg(ADDR_CTRL, 8'h00);
    talk_chk(3, 1'b0);
    run("R0X");
    talk_chk(0, 1'b0);
    run("Y2X");
    dclr <= 1'b1;
    @(posedge clk_in);
    dclr <= 1'b0;
    talk_chk(0, 1'b0);
    rdreg(ADDR_CTRL, 8'h00);
    // second reset in mid-run: control and rows return to defaults
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rdreg(ADDR_CTRL, 8'h01);
    rdreg(ADDR_MB, 8'h00);
    print_verdict();
  end
endmodule
